// file: ubg_pkg.sv
// Constants, types and helper functions for the four-channel baud rate generator
// Contract
// R1 - The base clock select register is a byte, reset to zero, upper nibble reads zero, lower nibble is the select field.
// R2 - Select codes 0 to 10 give the main clock divided by two to the power of the code; codes 12 to 15 are prohibited.
// R3 - Select code 11 takes the base clock from the external baud clock pin, valid on channel 0 only.
// R4 - Software clears the channel power bit before it rewrites the base clock select register.
// R5 - The baud divisor register is a byte, readable and writable, set to all ones by reset.
// R6 - Divisor values 4 to 255 are usable and the base clock over k forms the serial clock; 0 to 3 must not be written.
// R7 - Software rewrites the divisor only with power off or with both transmit and receive enables off.
// R8 - The bit rate is the base clock over twice k, so one bit lasts 2k base clocks.
// R9 - After a start bit the receiver times every following latch point from the divisor counter.
// R10 - The receive latch point leaves a margin of two base clocks, which sets the receive tolerance.
// R11 - A frame counts as 11 bits, all timed from the single start-bit resynchronisation.
// R12 - The remote transmitter keeps its baud rate within the receive tolerance for the chosen k.
// R13 - Software keeps this transmit rate error within the remote receiver tolerance.
// R14 - Software picks k and m by halving k from main clock over twice the rate until below 256, then rounding.
// R15 - Separate 8-bit divisor counters serve transmission and reception, each counting the base clock.
// R16 - The base clock reaches the counters only while the channel power bit is one.
// R17 - Each counter restarts on enable or start detection and ticks every k base clocks for mid-bit sampling.
package ubg_pkg;

  // Geometry
  localparam int          NUM_CH       = 4;
  localparam int          REG_W        = 8;
  localparam int          CKS_W        = 4;
  localparam int          PRESC_W      = 10;
  localparam int          CTL_STRIDE   = 4;

  // Reset values
  localparam logic [7:0]  CKS_RESET    = 8'h00;
  localparam logic [7:0]  BRS_RESET    = 8'hFF;
  localparam logic [11:0] CTL_RESET    = 12'h000;

  // Base clock select codes and the lowest usable divisor
  localparam logic [3:0]  CKS_MAX_DIV  = 4'hA;
  localparam logic [3:0]  CKS_EXT      = 4'hB;
  localparam logic [7:0]  BRS_MIN      = 8'h04;

  // Receive frame length in bits, start through stop
  localparam logic [3:0]  FRAME_BITS   = 4'hB;

  // Channel control field positions inside each nibble
  localparam int          RXE_POS      = 0;
  localparam int          TXE_POS      = 1;
  localparam int          PWR_POS      = 2;

  // Register indices as printed; byte address is four times the index
  localparam logic [31:0] IDX_CKS0     = 32'h0FFF_FA01;
  localparam logic [31:0] IDX_BRS0     = 32'h0FFF_FA02;
  localparam logic [31:0] IDX_CKS1     = 32'h0FFF_FA11;
  localparam logic [31:0] IDX_BRS1     = 32'h0FFF_FA12;
  localparam logic [31:0] IDX_CKS2     = 32'h0FFF_FA21;
  localparam logic [31:0] IDX_BRS2     = 32'hFFFF_FA22;
  localparam logic [31:0] IDX_CKS3     = 32'hFFFF_FA31;
  localparam logic [31:0] IDX_BRS3     = 32'hFFFF_FA32;

  // Extra registers for control and status bits
  localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT    = 32'h0000_0004;

  // AHB transfer types
  localparam logic [1:0]  HTRANS_NSEQ  = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ   = 2'b11;

  // Register kinds seen by the decoder
  typedef enum logic [2:0] {
    RK_NONE = 3'b000,
    RK_CKS  = 3'b001,
    RK_BRS  = 3'b010,
    RK_CTRL = 3'b011,
    RK_STAT = 3'b100
  } ubg_reg_kind_t;

  // Bus slave states
  typedef enum logic [0:0] {
    BS_IDLE = 1'b0,
    BS_RDWT = 1'b1
  } ubg_bus_state_t;

  // Index to byte address, upper index bits drop off the 32-bit bus
  function automatic logic [31:0] ubg_idx_addr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction : ubg_idx_addr

  // Low-bit mask whose all-ones state marks one period of fxx/2^m
  function automatic logic [PRESC_W-1:0] ubg_div_mask(input logic [3:0] m);
    logic [PRESC_W:0] one_hot;
    one_hot = '0;
    one_hot[m] = 1'b1;
    return PRESC_W'(one_hot - 1'b1);
  endfunction : ubg_div_mask

endpackage : ubg_pkg

// file: ubg_prescaler.sv
// Power-of-two prescaler of the main clock, advancing only while its run request is high
`timescale 1ns/1ps
module ubg_prescaler
  import ubg_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Run request
  input  wire logic              run_i,
  // One-cycle enables, bit m pulses once every 2^m cycles
  output logic [CKS_MAX_DIV:0]   tick_o
);

  logic [PRESC_W-1:0] cnt_ff;

  // Counter advances only while some channel is powered, saving toggles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (run_i) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Registered taps; a fixed one-cycle lag keeps the period exact
  // R2 power-of-two taps
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= '0;
    end else begin
      for (int m = 0; m <= int'(CKS_MAX_DIV); m++) begin
        tick_o[m] <= run_i & ((cnt_ff & ubg_div_mask(4'(m))) == ubg_div_mask(4'(m)));
      end
    end
  end

endmodule : ubg_prescaler

// file: ubg_div_counter.sv
// Eight-bit divisor counter producing half-bit strobes
`timescale 1ns/1ps
module ubg_div_counter
  import ubg_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             base_en_i,
  input  wire logic             run_i,
  input  wire logic             restart_i,
  input  wire logic [REG_W-1:0] div_k_i,
  // Strobes
  output logic                  mid_o,
  output logic                  edge_o
);

  logic [REG_W-1:0] cnt_ff;
  logic             phase_ff;
  logic             wrap;

  // R6 wrap after k
  assign wrap = base_en_i && (cnt_ff == div_k_i - 1'b1);

  // R17 restart and count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff   <= '0;
      phase_ff <= 1'b0;
    end else if (!run_i || restart_i) begin
      cnt_ff   <= '0;
      phase_ff <= 1'b0;
    end else if (wrap) begin
      cnt_ff   <= '0;
      phase_ff <= ~phase_ff;
    end else if (base_en_i) begin
      cnt_ff   <= cnt_ff + 1'b1;
    end
  end

  // R8 two halves per bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mid_o  <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      mid_o  <= run_i & ~restart_i & wrap & ~phase_ff;
      edge_o <= run_i & ~restart_i & wrap & phase_ff;
    end
  end

endmodule : ubg_div_counter

// file: ubg_baud_gen.sv
// Four-channel baud rate generator with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module ubg_baud_gen
  import ubg_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  // AHB-Lite slave
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  // External baud clock and start detection
  input  wire logic              ext_baud_clk_i,
  input  wire logic [NUM_CH-1:0] rx_start_i,
  // Per-channel timing strobes
  output logic [NUM_CH-1:0]      base_clk_en_o,
  output logic [NUM_CH-1:0]      tx_bit_tick_o,
  output logic [NUM_CH-1:0]      rx_latch_o,
  output logic [NUM_CH-1:0]      rx_frame_end_o
);

  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Release is delayed two edges so all flops leave reset together
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Register state
  logic [CKS_W-1:0]     cks_ff [NUM_CH];
  logic [REG_W-1:0]     brs_ff [NUM_CH];
  logic [11:0]          ctl_ff;

  // Bus state
  ubg_bus_state_t       bus_st_ff;
  logic                 wr_pend_ff;
  ubg_reg_kind_t        dp_kind_ff;
  logic [1:0]           dp_ch_ff;
  ubg_reg_kind_t        ap_kind;
  logic [1:0]           ap_ch;
  logic                 ap_valid;

  // Decode an address into register kind and channel
  function automatic ubg_reg_kind_t dec_kind(input logic [31:0] a);
    ubg_reg_kind_t k;
    k = RK_NONE;
    if (a == ubg_idx_addr(IDX_CKS0) || a == ubg_idx_addr(IDX_CKS1) ||
        a == ubg_idx_addr(IDX_CKS2) || a == ubg_idx_addr(IDX_CKS3)) begin
      k = RK_CKS;
    end else if (a == ubg_idx_addr(IDX_BRS0) || a == ubg_idx_addr(IDX_BRS1) ||
                 a == ubg_idx_addr(IDX_BRS2) || a == ubg_idx_addr(IDX_BRS3)) begin
      k = RK_BRS;
    end else if (a == ADDR_CTRL) begin
      k = RK_CTRL;
    end else if (a == ADDR_STAT) begin
      k = RK_STAT;
    end
    return k;
  endfunction : dec_kind

  function automatic logic [1:0] dec_ch(input logic [31:0] a);
    logic [1:0] c;
    c = 2'b00;
    if (a == ubg_idx_addr(IDX_CKS1) || a == ubg_idx_addr(IDX_BRS1)) begin
      c = 2'b01;
    end else if (a == ubg_idx_addr(IDX_CKS2) || a == ubg_idx_addr(IDX_BRS2)) begin
      c = 2'b10;
    end else if (a == ubg_idx_addr(IDX_CKS3) || a == ubg_idx_addr(IDX_BRS3)) begin
      c = 2'b11;
    end
    return c;
  endfunction : dec_ch

  // Per-channel control bit pick-out
  function automatic logic ctl_bit(input logic [11:0] c, input int ch, input int pos);
    return c[ch * CTL_STRIDE + pos];
  endfunction : ctl_bit

  // Address phase decode
  assign ap_valid = hsel_i && hready_i && (htrans_i == HTRANS_NSEQ || htrans_i == HTRANS_SEQ);
  assign ap_kind  = dec_kind(haddr_i);
  assign ap_ch    = dec_ch(haddr_i);

  // Bus handshake; reads take one wait state so a read right after a write sees it
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      bus_st_ff   <= BS_IDLE;
      wr_pend_ff  <= 1'b0;
      dp_kind_ff  <= RK_NONE;
      dp_ch_ff    <= 2'b00;
      hreadyout_o <= 1'b1;
    end else begin
      case (bus_st_ff)
        BS_IDLE: begin
          wr_pend_ff <= ap_valid & hwrite_i;
          if (ap_valid) begin
            dp_kind_ff <= ap_kind;
            dp_ch_ff   <= ap_ch;
          end
          if (ap_valid && !hwrite_i) begin
            bus_st_ff   <= BS_RDWT;
            hreadyout_o <= 1'b0;
          end
        end
        BS_RDWT: begin
          wr_pend_ff  <= 1'b0;
          bus_st_ff   <= BS_IDLE;
          hreadyout_o <= 1'b1;
        end
        default: begin
          wr_pend_ff  <= 1'b0;
          bus_st_ff   <= BS_IDLE;
          hreadyout_o <= 1'b1;
        end
      endcase
    end
  end

  // Every access is answered OKAY, unmapped ones included
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      hresp_o <= 1'b0;
    end else begin
      hresp_o <= 1'b0;
    end
  end

  // Register writes take the low bits of the data phase, twelve for control, eight for the divisor, four for select
  // R1 select register store
  // R5 divisor register store
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cks_ff[c] <= CKS_RESET[CKS_W-1:0];
        brs_ff[c] <= BRS_RESET;
      end
      ctl_ff <= CTL_RESET;
    end else if (wr_pend_ff) begin
      case (dp_kind_ff)
        RK_CKS:  cks_ff[dp_ch_ff] <= hwdata_i[CKS_W-1:0];
        RK_BRS:  brs_ff[dp_ch_ff] <= hwdata_i[REG_W-1:0];
        RK_CTRL: ctl_ff <= hwdata_i[11:0];
        default: ;
      endcase
    end
  end

  // Channel state for readback
  logic [NUM_CH-1:0] sel_bad;
  logic [NUM_CH-1:0] rx_active_ff;

  // Read data is loaded in the wait cycle, upper nibble of select reads zero
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      hrdata_o <= '0;
    end else if (bus_st_ff == BS_RDWT) begin
      case (dp_kind_ff)
        // R1 upper bits zero
        RK_CKS:  hrdata_o <= {28'h0000000, cks_ff[dp_ch_ff]};
        RK_BRS:  hrdata_o <= {24'h000000, brs_ff[dp_ch_ff]};
        RK_CTRL: hrdata_o <= {20'h00000, ctl_ff};
        RK_STAT: hrdata_o <= {24'h000000, rx_active_ff, sel_bad};
        default: hrdata_o <= '0;
      endcase
    end
  end

  // External pin rising edge gives one base clock per period
  logic ext_prev_ff;
  logic ext_rise;

  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_baud_clk_i;
    end
  end

  assign ext_rise = ext_baud_clk_i & ~ext_prev_ff;

  // Shared prescaler runs while any channel is powered
  logic                 any_pwr;
  logic [CKS_MAX_DIV:0] presc_tick;

  always_comb begin
    any_pwr = 1'b0;
    for (int c = 0; c < NUM_CH; c++) begin
      any_pwr = any_pwr | ctl_bit(ctl_ff, c, PWR_POS);
    end
  end

  ubg_prescaler u_presc (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_sync_ff),
    .run_i   (any_pwr),
    .tick_o  (presc_tick)
  );

  // Base clock selection per channel
  logic [NUM_CH-1:0] base_en;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      base_en[c] = 1'b0;
      sel_bad[c] = 1'b0;
      if (cks_ff[c] <= CKS_MAX_DIV) begin
        // R2 divided main clock
        base_en[c] = presc_tick[cks_ff[c]];
      end else if (cks_ff[c] == CKS_EXT && c == 0) begin
        // R3 external pin
        base_en[c] = ext_rise;
      end else begin
        // Prohibited codes stop the base clock and show in status
        sel_bad[c] = 1'b1;
      end
      // R16 power gate
      base_en[c] = base_en[c] & ctl_bit(ctl_ff, c, PWR_POS);
    end
  end

  // Enable edges restart the transmit counters so the first bit is full length
  logic [NUM_CH-1:0] tx_run;
  logic [NUM_CH-1:0] rx_en;
  logic [NUM_CH-1:0] tx_run_prev_ff;
  logic [NUM_CH-1:0] rx_start;
  logic [NUM_CH-1:0] rx_mid;
  logic [NUM_CH-1:0] tx_edge;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      tx_run[c]   = ctl_bit(ctl_ff, c, PWR_POS) & ctl_bit(ctl_ff, c, TXE_POS);
      rx_en[c]    = ctl_bit(ctl_ff, c, PWR_POS) & ctl_bit(ctl_ff, c, RXE_POS);
      rx_start[c] = rx_en[c] & rx_start_i[c];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      tx_run_prev_ff <= '0;
    end else begin
      tx_run_prev_ff <= tx_run;
    end
  end

  // R11 frame bit count
  logic [3:0] rx_bits_ff [NUM_CH];

  // Receive runs from start detection until the 11th latch point
  // R9 resync per frame
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rx_active_ff <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        rx_bits_ff[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!rx_en[c]) begin
          rx_active_ff[c] <= 1'b0;
          rx_bits_ff[c]   <= '0;
        end else if (rx_start[c] && !rx_active_ff[c]) begin
          rx_active_ff[c] <= 1'b1;
          rx_bits_ff[c]   <= '0;
        end else if (rx_mid[c]) begin
          rx_bits_ff[c] <= rx_bits_ff[c] + 1'b1;
          if (rx_bits_ff[c] == FRAME_BITS - 1'b1) begin
            rx_active_ff[c] <= 1'b0;
          end
        end
      end
    end
  end

  // R15 separate counters
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    ubg_div_counter u_tx (
      .clk_i     (clk_sys_i),
      .rst_n_i   (rst_sync_ff),
      .base_en_i (base_en[g]),
      .run_i     (tx_run[g]),
      // R17 restart on enable
      .restart_i (tx_run[g] & ~tx_run_prev_ff[g]),
      .div_k_i   (brs_ff[g]),
      .mid_o     (),
      .edge_o    (tx_edge[g])
    );

    // R10 latch k clocks in
    ubg_div_counter u_rx (
      .clk_i     (clk_sys_i),
      .rst_n_i   (rst_sync_ff),
      .base_en_i (base_en[g]),
      .run_i     (rx_active_ff[g]),
      .restart_i (rx_start[g] & ~rx_active_ff[g]),
      .div_k_i   (brs_ff[g]),
      .mid_o     (rx_mid[g]),
      .edge_o    ()
    );
  end

  // Output strobes are re-timed so every port leaves a flop here
  // R8 bit boundary out
  always_ff @(posedge clk_sys_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      base_clk_en_o  <= '0;
      tx_bit_tick_o  <= '0;
      rx_latch_o     <= '0;
      rx_frame_end_o <= '0;
    end else begin
      base_clk_en_o <= base_en;
      tx_bit_tick_o <= tx_edge;
      rx_latch_o    <= rx_mid & rx_active_ff;
      for (int c = 0; c < NUM_CH; c++) begin
        rx_frame_end_o[c] <= rx_mid[c] & rx_active_ff[c] & (rx_bits_ff[c] == FRAME_BITS - 1'b1);
      end
    end
  end

endmodule : ubg_baud_gen

// file: ubg_baud_gen_sva.sv
// Port-level assertion checker for the baud rate generator
`timescale 1ns/1ps
module ubg_baud_gen_sva
  import ubg_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  // Bus
  input  wire logic              hsel_i,
  input  wire logic [31:0]       haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  input  wire logic              hreadyout_o,
  input  wire logic              hresp_o,
  input  wire logic [31:0]       hrdata_o,
  // Strobes
  input  wire logic [NUM_CH-1:0] base_clk_en_o,
  input  wire logic [NUM_CH-1:0] tx_bit_tick_o,
  input  wire logic [NUM_CH-1:0] rx_latch_o,
  input  wire logic [NUM_CH-1:0] rx_frame_end_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  logic       req;
  logic       rd_ph_ff;
  logic       ctl_ph_ff;
  logic       pwr0_ff;
  logic [1:0] off_cnt_ff;
  logic [3:0] latch_cnt_ff;

  assign req = hsel_i && hready_i && htrans_i[1];

  // Data phase tracking and a shadow of the channel 0 power bit
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ph_ff  <= 1'b0;
      ctl_ph_ff <= 1'b0;
      pwr0_ff   <= 1'b0;
    end else if (hreadyout_o) begin
      rd_ph_ff  <= req && !hwrite_i;
      ctl_ph_ff <= req && hwrite_i && (haddr_i == ADDR_CTRL);
      if (ctl_ph_ff) begin
        pwr0_ff <= hwdata_i[PWR_POS];
      end
    end
  end

  // Cycles with channel 0 unpowered; margin covers the strobe pipeline
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_cnt_ff <= 2'h0;
    end else if (pwr0_ff) begin
      off_cnt_ff <= 2'h0;
    end else if (off_cnt_ff != 2'h3) begin
      off_cnt_ff <= off_cnt_ff + 2'h1;
    end
  end

  // Latches seen so far in the current channel 0 frame
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      latch_cnt_ff <= 4'h0;
    end else if (rx_frame_end_o[0]) begin
      latch_cnt_ff <= 4'h0;
    end else if (rx_latch_o[0]) begin
      latch_cnt_ff <= latch_cnt_ff + 4'h1;
    end
  end

  sequence rd_req_s;
    req && !hwrite_i;
  endsequence
  sequence rd_ans_s;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  okay_resp_a: assert property (!hresp_o)
    else $error("bus response not OKAY");
  write_nowait_a: assert property (req && hwrite_i |=> hreadyout_o)
    else $error("write data phase stalled");
  read_wait_a: assert property (rd_req_s |=> rd_ans_s)
    else $error("read answer not after one wait cycle");
  upper_zero_a: assert property (rd_ph_ff && hreadyout_o |-> hrdata_o[31:12] == 20'h0)
    else $error("read data upper bits not zero");
  tick_spacing_a: assert property (tx_bit_tick_o[0] |=> !tx_bit_tick_o[0] [*7])
    else $error("bit ticks closer than 2k base clocks");
  latch_spacing_a: assert property (rx_latch_o[0] |=> !rx_latch_o[0] [*3])
    else $error("receive latches too close");
  frame_count_a: assert property (rx_frame_end_o[0] |-> rx_latch_o[0] && latch_cnt_ff == 4'hA)
    else $error("frame end not on the eleventh latch");
  power_gate_a: assert property (off_cnt_ff == 2'h3 |-> !base_clk_en_o[0])
    else $error("base clock while channel unpowered");
endmodule : ubg_baud_gen_sva

bind ubg_baud_gen ubg_baud_gen_sva u_sva (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
  .base_clk_en_o(base_clk_en_o), .tx_bit_tick_o(tx_bit_tick_o),
  .rx_latch_o(rx_latch_o), .rx_frame_end_o(rx_frame_end_o)
);

// file: ubg_remote_party.sv
// Remote serial party: start-bit source and external base clock
`timescale 1ns/1ps
module ubg_remote_party
  import ubg_pkg::*;
(
  // Clock
  input  wire logic         clk_i,
  // External clock run request
  input  wire logic         ext_run_i,
  // Pins toward the generator
  output logic              ext_clk_o,
  output logic [NUM_CH-1:0] start_o
);
  logic [1:0] cnt_ff;

  initial begin
    cnt_ff    = 2'h0;
    ext_clk_o = 1'b0;
    start_o   = '0;
  end

  // rising edge every four cycles, parked low when not running
  always @(posedge clk_i) begin
    cnt_ff    <= ext_run_i ? cnt_ff + 2'h1 : 2'h0;
    ext_clk_o <= ext_run_i && cnt_ff[1];
  end

  // one frame at the nominal rate, then the two-clock stop gap
  task automatic send_frame(input int ch, input int bit_cyc);
    @(posedge clk_i);
    start_o[ch] <= 1'b1;
    @(posedge clk_i);
    start_o[ch] <= 1'b0;
    repeat (FRAME_BITS * bit_cyc + 2) @(posedge clk_i);
  endtask : send_frame
endmodule : ubg_remote_party

// file: ubg_baud_gen_tb.sv
// Self-checking bench for the four-channel baud rate generator
`timescale 1ns/1ps
module ubg_baud_gen_tb
  import ubg_pkg::*;
;
  localparam logic [31:0] CKS_IDX [4] = '{IDX_CKS0, IDX_CKS1, IDX_CKS2, IDX_CKS3};
  localparam logic [31:0] BRS_IDX [4] = '{IDX_BRS0, IDX_BRS1, IDX_BRS2, IDX_BRS3};

  logic              clk_sys_i;
  logic              reset_n_i;
  logic              hsel;
  logic              hwrite;
  logic              hready;
  logic              hresp;
  logic              ext_run;
  logic              ext_clk;
  logic              rd_ph;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [7:0]        k;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       r;
  logic [NUM_CH-1:0] rx_start;
  logic [NUM_CH-1:0] base_en;
  logic [NUM_CH-1:0] tx_tick;
  logic [NUM_CH-1:0] rx_latch;
  logic [NUM_CH-1:0] rx_end;
  int                failures;
  int                num_checks;
  int                cyc;
  int                seed;
  int                last_tick;
  int                lcnt;
  int                first_l;
  logic [31:0]       rd_q[$];
  int                per_q[$];
  int                cnt_q[$];
  int                span_q[$];

  ubg_baud_gen dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .ext_baud_clk_i(ext_clk), .rx_start_i(rx_start), .base_clk_en_o(base_en),
    .tx_bit_tick_o(tx_tick), .rx_latch_o(rx_latch), .rx_frame_end_o(rx_end)
  );

  ubg_remote_party rmt (
    .clk_i(clk_sys_i), .ext_run_i(ext_run), .ext_clk_o(ext_clk), .start_o(rx_start)
  );

  // 20 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Hang guard, well above the longest period sweep
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failures++;
      test_done();
    end
  end

  function automatic logic [31:0] ad(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction : ad

  // One single transfer; a read leaves its expected word as a note
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk_sys_i);
    hsel   <= 1'b1;
    haddr  <= addr;
    hwrite <= wr;
    htrans <= HTRANS_NSEQ;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? data : 32'h0;
    if (!wr) rd_q.push_back(data);
    do @(posedge clk_sys_i); while (hready !== 1'b1);
  endtask : bus

  // power down before touching select or divisor
  task automatic set_mode(input int ch, input logic [3:0] code, input logic [7:0] kv, input logic [11:0] ctl);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b1, ad(CKS_IDX[ch]), {28'h0, code});
    bus(1'b1, ad(BRS_IDX[ch]), {24'h0, kv});
    bus(1'b1, ADDR_CTRL, {20'h0, ctl});
  endtask : set_mode

  // Note the period expected after the next channel 0 tick, then wait for its check
  task automatic measure(input int period);
    do @(negedge clk_sys_i); while (tx_tick[0] !== 1'b1);
    @(posedge clk_sys_i);
    #1;
    per_q.push_back(period);
    while (per_q.size() > 0) @(posedge clk_sys_i);
  endtask : measure

  // Watcher: compares each result with the oldest note
  always @(posedge clk_sys_i) begin
    if (rd_ph && hready && rd_q.size() > 0) begin
      chk("read data", rd_q.pop_front(), hrdata);
    end
    if (hready) begin
      rd_ph <= hsel && htrans[1] && !hwrite;
    end
    if (tx_tick[0]) begin
      if (per_q.size() > 0) chk("bit period", per_q.pop_front(), cyc - last_tick);
      last_tick = cyc;
    end
    if (rx_latch[0]) begin
      if (lcnt == 0) first_l = cyc;
      lcnt++;
    end
    if (rx_end[0]) begin
      if (cnt_q.size() > 0) begin
        chk("latch count", cnt_q.pop_front(), lcnt);
        chk("frame span", span_q.pop_front(), cyc - first_l);
      end
      lcnt = 0;
    end
  end

  initial begin
    seed       = 29763;
    cyc        = 0;
    failures   = 0;
    num_checks = 0;
    lcnt       = 0;
    last_tick  = 0;
    first_l    = 0;
    rd_ph      = 1'b0;
    reset_n_i  = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    hwdata     = 32'h0;
    ext_run    = 1'b0;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    // reset values, then an unmapped place
    for (int c = 0; c < NUM_CH; c++) begin
      bus(1'b0, ad(CKS_IDX[c]), {24'h0, CKS_RESET});
      bus(1'b0, ad(BRS_IDX[c]), {24'h0, BRS_RESET});
    end
    bus(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0100, 32'h0);
    // upper select bits stay zero, divisor keeps a legal byte
    r = $random(seed);
    r[7] = 1'b1;
    bus(1'b1, ad(CKS_IDX[2]), r | 32'hFFFF_FFF0);
    bus(1'b0, ad(CKS_IDX[2]), {28'h0, r[3:0]});
    bus(1'b1, ad(BRS_IDX[2]), r);
    bus(1'b0, ad(BRS_IDX[2]), {24'h0, r[7:0]});
    // reset divisor with m of 0
    set_mode(0, 4'h0, BRS_RESET, 12'h006);
    measure(2 * 255);
    // every internal select code with a random small divisor
    for (int m = 0; m <= 10; m++) begin
      k = BRS_MIN + 8'($random(seed) & 1);
      set_mode(0, m[3:0], k, 12'h006);
      measure((2 * k) << m);
    end
    // external pin: one base clock every four cycles
    ext_run <= 1'b1;
    set_mode(0, CKS_EXT, BRS_MIN, 12'h006);
    measure(2 * 4 * 4);
    ext_run <= 1'b0;
    // two back-to-back frames with k of four
    set_mode(0, 4'h0, BRS_MIN, 12'h005);
    repeat (2) begin
      cnt_q.push_back(FRAME_BITS);
      span_q.push_back(10 * 2 * 4);
      rmt.send_frame(0, 8);
    end
    // prohibited codes raise their channel status flags
    for (int c = 12; c < 16; c++) begin
      set_mode(0, c[3:0], BRS_MIN, 12'h000);
      set_mode(1, CKS_EXT, BRS_MIN, 12'h044);
      bus(1'b0, ADDR_STAT, {29'h0, r[3:0] >= CKS_EXT, 2'h3});
    end
    test_done();
  end
endmodule : ubg_baud_gen_tb
